// [rtl/bad_core.sv]
// Operation
// - add-immediate adds the low-byte literal to the accumulator, result to accumulator
// - add-to-file adds accumulator to the 8-bit addressed file register
// - destination bit zero stores to accumulator, one stores back to file
// - access bit zero selects quick-access bank, one uses bank select register
// - extended set, access zero, address up to 5Fh uses indexed literal offset
// - both adds update N, OV, C, DC, Z; one word, one instruction cycle
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "bad_regs.svh"
module bad_core #(
	parameter int AW = 12
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	bad_pkg::bad_state_t state_r, state_nxt;
	logic          aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
	logic [7:0]    awaddr_r, awaddr_nxt, araddr_r, araddr_nxt;
	logic [31:0]   wdata_r, wdata_nxt, wmask_r, wmask_nxt;
	logic          bvalid_r, bvalid_nxt, rpend_r, rpend_nxt;
	logic [1:0]    bresp_r, bresp_nxt;
	logic [31:0]   rdata_r, rdata_nxt;
	logic          rvalid_r, rvalid_nxt;
	logic          ext_r, ext_nxt, uns_r, uns_nxt;
	logic [15:0]   instr_r, instr_nxt;
	logic [7:0]    accum_r, accum_nxt, sum_r, sum_nxt;
	logic [3:0]    bank_r, bank_nxt;
	logic [4:0]    flags_r, flags_nxt, fres_r, fres_nxt;
	logic [AW-1:0] index_r, index_nxt, maddr_r, maddr_nxt, faddr_r, faddr_nxt;
	logic          is_lit_r, is_lit_nxt, is_file_r, is_file_nxt;
	logic          mem_we;
	logic [AW-1:0] mem_waddr, mem_raddr;
	logic [7:0]    mem_wdata, mem_rdata, operand;
	logic [8:0]    sum9;
	logic [4:0]    dsum;
	logic          busy, do_write;
	logic [31:0]   wr_val, lane_mask;

	assign busy          = (state_r != bad_pkg::BAD_IDLE);
	assign s_axi_awready = !aw_held_r && !bvalid_r && !busy;
	assign s_axi_wready  = !w_held_r && !bvalid_r && !busy;
	assign s_axi_arready = !rpend_r && !rvalid_r && !busy;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = (araddr_r > `BAD_MDATA_OFS || araddr_r[1:0] != 2'h0) ?
		`BAD_RESP_SLVERR : `BAD_RESP_OKAY;
	assign do_write      = aw_held_r && w_held_r && !bvalid_r;
	assign wr_val        = wdata_r & wmask_r;

	for (genvar gi = 0; gi < 4; gi++) begin : g_lane
		assign lane_mask[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
	end

	// literal comes from the opcode, file operand from the memory read
	assign operand = is_lit_r ? instr_r[7:0] : mem_rdata;
	assign sum9    = {1'b0, accum_r} + {1'b0, operand};
	assign dsum    = {1'b0, accum_r[3:0]} + {1'b0, operand[3:0]};

	// memory read port is the executing address, else the software window
	assign mem_raddr = busy ? faddr_r : maddr_r;
	assign mem_we    = (state_r == bad_pkg::BAD_Q4 && is_file_r && instr_r[`BAD_DEST_BIT]) ||
		(do_write && awaddr_r == `BAD_MDATA_OFS && wmask_r[0]);
	assign mem_waddr = busy ? faddr_r : maddr_r;
	assign mem_wdata = busy ? sum_r : wdata_r[7:0];

	bad_file_mem #(.AW(AW)) u_mem (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (mem_we),
		.waddr   (mem_waddr),
		.wdata   (mem_wdata),
		.raddr   (mem_raddr),
		.rdata   (mem_rdata)
	);

	always_comb begin
		state_nxt   = state_r;
		aw_held_nxt = aw_held_r;
		w_held_nxt  = w_held_r;
		awaddr_nxt  = awaddr_r;
		araddr_nxt  = araddr_r;
		wdata_nxt   = wdata_r;
		wmask_nxt   = wmask_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		rpend_nxt   = 1'b0;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		ext_nxt     = ext_r;
		uns_nxt     = uns_r;
		instr_nxt   = instr_r;
		accum_nxt   = accum_r;
		sum_nxt     = sum_r;
		bank_nxt    = bank_r;
		flags_nxt   = flags_r;
		fres_nxt    = fres_r;
		index_nxt   = index_r;
		maddr_nxt   = maddr_r;
		faddr_nxt   = faddr_r;
		is_lit_nxt  = is_lit_r;
		is_file_nxt = is_file_r;

		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_nxt = 1'b1;
			awaddr_nxt  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_nxt = 1'b1;
			wdata_nxt  = s_axi_wdata;
			wmask_nxt  = lane_mask;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end

		if (do_write) begin
			aw_held_nxt = 1'b0;
			w_held_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = `BAD_RESP_OKAY;
			case (awaddr_r)
				`BAD_CTRL_OFS: begin
					if (wmask_r[`BAD_CTRL_EXT_BIT]) begin
						ext_nxt = wdata_r[`BAD_CTRL_EXT_BIT];
					end
					if (wr_val[`BAD_CTRL_UNS_BIT]) begin
						uns_nxt = 1'b0;
					end
				end
				`BAD_INSTR_OFS: begin
					instr_nxt = (instr_r & ~wmask_r[15:0]) | wr_val[15:0];
					// only a full low half-word starts an instruction
					if (wmask_r[15:0] == 16'hffff) begin
						state_nxt = bad_pkg::BAD_Q1;
					end
				end
				`BAD_ACCUM_OFS: accum_nxt = (accum_r & ~wmask_r[7:0]) | wr_val[7:0];
				`BAD_BANK_OFS:  bank_nxt  = (bank_r & ~wmask_r[3:0]) | wr_val[3:0];
				`BAD_FLAGS_OFS: flags_nxt = (flags_r & ~wmask_r[4:0]) | wr_val[4:0];
				`BAD_INDEX_OFS: index_nxt = (index_r & ~wmask_r[AW-1:0]) | wr_val[AW-1:0];
				`BAD_MADDR_OFS: maddr_nxt = (maddr_r & ~wmask_r[AW-1:0]) | wr_val[AW-1:0];
				`BAD_MDATA_OFS: ;
				default: bresp_nxt = `BAD_RESP_SLVERR;
			endcase
		end

		// read: data sampled one cycle after the address, memory is registered
		if (s_axi_arvalid && s_axi_arready) begin
			araddr_nxt = s_axi_araddr;
			rpend_nxt  = 1'b1;
		end
		if (rpend_r) begin
			rvalid_nxt = 1'b1;
			case (araddr_r)
				`BAD_CTRL_OFS: begin
					rdata_nxt = 32'h0000_0000;
					rdata_nxt[`BAD_CTRL_EXT_BIT] = ext_r;
					rdata_nxt[`BAD_CTRL_UNS_BIT] = uns_r;
				end
				`BAD_INSTR_OFS: rdata_nxt = {16'h0000, instr_r};
				`BAD_ACCUM_OFS: rdata_nxt = {24'h00_0000, accum_r};
				`BAD_BANK_OFS:  rdata_nxt = {28'h000_0000, bank_r};
				`BAD_FLAGS_OFS: rdata_nxt = {27'h000_0000, flags_r};
				`BAD_INDEX_OFS: rdata_nxt = {{(32-AW){1'b0}}, index_r};
				`BAD_MADDR_OFS: rdata_nxt = {{(32-AW){1'b0}}, maddr_r};
				`BAD_MDATA_OFS: rdata_nxt = {24'h00_0000, mem_rdata};
				default:        rdata_nxt = 32'h0000_0000;
			endcase
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end

		case (state_r)
			bad_pkg::BAD_IDLE: ;
			bad_pkg::BAD_Q1: begin
				is_lit_nxt  = (instr_r[15:8] == `BAD_OP_LIT);
				is_file_nxt = (instr_r[15:10] == `BAD_OP_FILE);
				if (!instr_r[`BAD_ACC_BIT]) begin
					if (ext_r && instr_r[7:0] <= `BAD_INDEX_MAX) begin
						faddr_nxt = index_r + AW'(instr_r[7:0]);
					end else if (instr_r[7:0] < `BAD_ACCESS_SPLIT) begin
						faddr_nxt = AW'({`BAD_ACCESS_LOW, instr_r[7:0]});
					end else begin
						faddr_nxt = AW'({`BAD_ACCESS_HIGH, instr_r[7:0]});
					end
				end else begin
					faddr_nxt = AW'({bank_r, instr_r[7:0]});
				end
				state_nxt = bad_pkg::BAD_Q2;
			end
			bad_pkg::BAD_Q2: state_nxt = bad_pkg::BAD_Q3;
			bad_pkg::BAD_Q3: begin
				sum_nxt = sum9[7:0];
				fres_nxt[`BAD_FLAG_C]  = sum9[8];
				fres_nxt[`BAD_FLAG_DC] = dsum[4];
				fres_nxt[`BAD_FLAG_Z]  = (sum9[7:0] == 8'h00);
				fres_nxt[`BAD_FLAG_OV] = (accum_r[7] == operand[7]) &&
					(sum9[7] != accum_r[7]);
				fres_nxt[`BAD_FLAG_N]  = sum9[7];
				state_nxt = bad_pkg::BAD_Q4;
			end
			bad_pkg::BAD_Q4: begin
				if (is_lit_r || (is_file_r && !instr_r[`BAD_DEST_BIT])) begin
					accum_nxt = sum_r;
				end
				if (is_lit_r || is_file_r) begin
					flags_nxt = fres_r;
				end else begin
					// other opcodes are not executed, they only set the sticky uns bit
					uns_nxt = 1'b1;
				end
				state_nxt = bad_pkg::BAD_IDLE;
			end
			default: state_nxt = bad_pkg::BAD_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r   <= bad_pkg::BAD_IDLE;
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			araddr_r  <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wmask_r   <= 32'h0000_0000;
			bvalid_r  <= 1'b0;
			bresp_r   <= `BAD_RESP_OKAY;
			rpend_r   <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			ext_r     <= 1'b0;
			uns_r     <= 1'b0;
			instr_r   <= `BAD_INSTR_RST;
			accum_r   <= `BAD_ACCUM_RST;
			sum_r     <= 8'h00;
			bank_r    <= `BAD_BANK_RST;
			flags_r   <= `BAD_FLAGS_RST;
			fres_r    <= `BAD_FLAGS_RST;
			index_r   <= '0;
			maddr_r   <= '0;
			faddr_r   <= '0;
			is_lit_r  <= 1'b0;
			is_file_r <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			aw_held_r <= aw_held_nxt;
			w_held_r  <= w_held_nxt;
			awaddr_r  <= awaddr_nxt;
			araddr_r  <= araddr_nxt;
			wdata_r   <= wdata_nxt;
			wmask_r   <= wmask_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rpend_r   <= rpend_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			ext_r     <= ext_nxt;
			uns_r     <= uns_nxt;
			instr_r   <= instr_nxt;
			accum_r   <= accum_nxt;
			sum_r     <= sum_nxt;
			bank_r    <= bank_nxt;
			flags_r   <= flags_nxt;
			fres_r    <= fres_nxt;
			index_r   <= index_nxt;
			maddr_r   <= maddr_nxt;
			faddr_r   <= faddr_nxt;
			is_lit_r  <= is_lit_nxt;
			is_file_r <= is_file_nxt;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	lit_sum_a: assert property (
		state_r == bad_pkg::BAD_Q4 && is_lit_r |=>
		accum_r == 8'($past(accum_r) + $past(instr_r[7:0])))
		else $error("immediate add result wrong");
	file_sum_a: assert property (
		state_r == bad_pkg::BAD_Q4 && is_file_r |->
		sum_r == 8'($past(accum_r) + $past(mem_rdata)))
		else $error("file add result wrong");
	file_dest_a: assert property (
		state_r == bad_pkg::BAD_Q4 && is_file_r |->
		(mem_we == instr_r[9]) ##1 (accum_r == (instr_r[9] ? $past(accum_r) : $past(sum_r))))
		else $error("add destination wrong");
	bank_addr_a: assert property (
		state_r == bad_pkg::BAD_Q2 && instr_r[8] |-> faddr_r == AW'({bank_r, instr_r[7:0]}))
		else $error("banked address wrong");
	indexed_addr_a: assert property (
		state_r == bad_pkg::BAD_Q2 && !instr_r[8] && ext_r && instr_r[7:0] <= `BAD_INDEX_MAX
		|-> faddr_r == AW'(index_r + AW'(instr_r[7:0])))
		else $error("indexed address wrong");
	instr_cycle_a: assert property (
		state_r == bad_pkg::BAD_Q1 |-> ##3 state_r == bad_pkg::BAD_Q4 ##1 !busy)
		else $error("instruction cycle length wrong");
	flag_zn_a: assert property (
		state_r == bad_pkg::BAD_Q4 && is_lit_r |=>
		flags_r[`BAD_FLAG_Z] == (accum_r == 8'h00) && flags_r[`BAD_FLAG_N] == accum_r[7] &&
		flags_r[`BAD_FLAG_C] == ({1'b0, $past(accum_r)} + {1'b0, $past(instr_r[7:0])} > 9'h0ff))
		else $error("add flags wrong");
endmodule

// [rtl/bad_file_mem.sv]
`timescale 1ns/1ns
module bad_file_mem #(
	parameter int AW = 12
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [7:0]    rdata
);
	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read data one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// [rtl/bad_pkg.sv]
package bad_pkg;

	typedef enum logic [4:0] {
		BAD_IDLE = 5'h01,
		BAD_Q1   = 5'h02,
		BAD_Q2   = 5'h04,
		BAD_Q3   = 5'h08,
		BAD_Q4   = 5'h10
	} bad_state_t;

endpackage

// [rtl/bad_regs.svh]
`ifndef BAD_REGS_SVH
`define BAD_REGS_SVH

// register byte offsets
`define BAD_CTRL_OFS     8'h00
`define BAD_INSTR_OFS    8'h04
`define BAD_ACCUM_OFS    8'h08
`define BAD_BANK_OFS     8'h0c
`define BAD_FLAGS_OFS    8'h10
`define BAD_INDEX_OFS    8'h14
`define BAD_MADDR_OFS    8'h18
`define BAD_MDATA_OFS    8'h1c

// control register fields
`define BAD_CTRL_EXT_BIT 0
`define BAD_CTRL_BSY_BIT 8
`define BAD_CTRL_UNS_BIT 9

// flag positions
`define BAD_FLAG_C       0
`define BAD_FLAG_DC      1
`define BAD_FLAG_Z       2
`define BAD_FLAG_OV      3
`define BAD_FLAG_N       4

// opcode decode
`define BAD_OP_LIT       8'h0f
`define BAD_OP_FILE      6'h09
`define BAD_DEST_BIT     9
`define BAD_ACC_BIT      8
`define BAD_INDEX_MAX    8'h5f
`define BAD_ACCESS_SPLIT 8'h80
`define BAD_ACCESS_HIGH  4'hf
`define BAD_ACCESS_LOW   4'h0

// reset values
`define BAD_ACCUM_RST    8'h00
`define BAD_BANK_RST     4'h0
`define BAD_FLAGS_RST    5'h00
`define BAD_INSTR_RST    16'h0000

// bus answers
`define BAD_RESP_OKAY    2'h0
`define BAD_RESP_SLVERR  2'h2

`endif

// [verification/bad_core_test.sv]
`timescale 1ns/1ns
`include "bad_regs.svh"
module bad_core_test;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	int          n_errors = 0;
	int          n_checks = 0;
	// add-immediate cases: plain, carry+zero, signed overflow, both tops, nibble carry
	logic [7:0]  iw [5] = '{8'h10, 8'hff, 8'h7f, 8'h80, 8'h08};
	logic [7:0]  ik [5] = '{8'h15, 8'h01, 8'h01, 8'h80, 8'h08};
	// add-to-file cases: banked, access low/high, indexed, index edge, ext with banked
	logic        fx [7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
	logic [15:0] fo [7] = '{16'h2542, 16'h2742, 16'h2610, 16'h2490, 16'h265f, 16'h2660,
		16'h2720};
	logic [11:0] fa [7] = '{12'h342, 12'h342, 12'h010, 12'hf90, 12'h25f, 12'h060, 12'h320};
	logic [7:0]  fv [7] = '{8'hc2, 8'hc2, 8'h7f, 8'h80, 8'h0f, 8'hff, 8'h33};
	logic [7:0]  fw [7] = '{8'h17, 8'hd9, 8'h01, 8'h80, 8'h01, 8'h01, 8'h4d};

	bad_core #(.AW(12)) DUT (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (1'h1),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (1'h1)
	);

	always #5 aclk = ~aclk;

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// bready/rready are tied high, so the answer is taken at the edge it is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic done;
		done = 1'h0;
		resp = 2'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (int n = 0; n < 100 && !done; n++) begin
			@(posedge aclk);
			if (s_axi_bvalid) begin
				resp = s_axi_bresp;
				done = 1'h1;
			end
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end
		if (!done) begin
			n_errors++;
			close_out();
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic done;
		done = 1'h0;
		d = 32'h0;
		resp = 2'h0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (int n = 0; n < 100 && !done; n++) begin
			@(posedge aclk);
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				resp = s_axi_rresp;
				done = 1'h1;
			end
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end
		if (!done) begin
			n_errors++;
			close_out();
		end
	endtask

	task automatic wo(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", {30'h0, r}, {30'h0, `BAD_RESP_OKAY});
	endtask

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(nm, d, exp);
		chk("rresp", {30'h0, r}, {30'h0, `BAD_RESP_OKAY});
	endtask

	// expected sum in [7:0], flags in [12:8]
	function automatic logic [31:0] sum_flags(input logic [7:0] x, input logic [7:0] y);
		logic [8:0] s;
		logic [4:0] f;
		s = {1'h0, x} + {1'h0, y};
		f[`BAD_FLAG_C] = s[8];
		f[`BAD_FLAG_DC] = ({1'h0, x[3:0]} + {1'h0, y[3:0]}) > 5'h0f;
		f[`BAD_FLAG_Z] = (s[7:0] == 8'h00);
		f[`BAD_FLAG_OV] = (x[7] == y[7]) && (s[7] != x[7]);
		f[`BAD_FLAG_N] = s[7];
		return {19'h0, f, s[7:0]};
	endfunction

	initial begin
		logic [31:0] e;
		logic [31:0] d;
		logic [1:0]  r;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rc("accum", `BAD_ACCUM_OFS, 32'h0);
		rc("flags", `BAD_FLAGS_OFS, 32'h0);
		rc("bank", `BAD_BANK_OFS, 32'h0);
		// unmapped places answer with an error and zero data
		rd(8'h20, d, r);
		chk("unmapped rdata", d, 32'h0);
		chk("unmapped rresp", {30'h0, r}, {30'h0, `BAD_RESP_SLVERR});
		wr(8'h24, 32'h5a, r);
		chk("unmapped bresp", {30'h0, r}, {30'h0, `BAD_RESP_SLVERR});
		for (int i = 0; i < 5; i++) begin
			e = sum_flags(iw[i], ik[i]);
			wo(`BAD_ACCUM_OFS, {24'h0, iw[i]});
			wo(`BAD_INSTR_OFS, {16'h0, `BAD_OP_LIT, ik[i]});
			rc("imm accum", `BAD_ACCUM_OFS, {24'h0, e[7:0]});
			rc("imm flags", `BAD_FLAGS_OFS, {27'h0, e[12:8]});
		end
		wo(`BAD_BANK_OFS, 32'h3);
		wo(`BAD_INDEX_OFS, 32'h200);
		for (int i = 0; i < 7; i++) begin
			e = sum_flags(fw[i], fv[i]);
			wo(`BAD_CTRL_OFS, {31'h0, fx[i]});
			wo(`BAD_MADDR_OFS, {20'h0, fa[i]});
			wo(`BAD_MDATA_OFS, {24'h0, fv[i]});
			wo(`BAD_ACCUM_OFS, {24'h0, fw[i]});
			wo(`BAD_INSTR_OFS, {16'h0, fo[i]});
			rc("file accum", `BAD_ACCUM_OFS, {24'h0, fo[i][9] ? fw[i] : e[7:0]});
			rc("file data", `BAD_MDATA_OFS, {24'h0, fo[i][9] ? e[7:0] : fv[i]});
			rc("file flags", `BAD_FLAGS_OFS, {27'h0, e[12:8]});
		end
		// an opcode outside the two adds only raises the sticky bit
		wo(`BAD_CTRL_OFS, 32'h0);
		wo(`BAD_INSTR_OFS, 32'h0b12);
		rc("sticky set", `BAD_CTRL_OFS, 32'h1 << `BAD_CTRL_UNS_BIT);
		rc("other accum", `BAD_ACCUM_OFS, {24'h0, fw[6]});
		wo(`BAD_CTRL_OFS, 32'h1 << `BAD_CTRL_UNS_BIT);
		rc("sticky clear", `BAD_CTRL_OFS, 32'h0);
		// a partial instruction write merges its lane but does not execute
		s_axi_wstrb <= 4'h1;
		wo(`BAD_INSTR_OFS, {16'h0, `BAD_OP_LIT, 8'h01});
		s_axi_wstrb <= 4'hf;
		rc("instr merge", `BAD_INSTR_OFS, 32'h0b01);
		rc("no start accum", `BAD_ACCUM_OFS, {24'h0, fw[6]});
		close_out();
	end
endmodule
